// ==== bal_regs.svh ====
`ifndef BAL_REGS_SVH
`define BAL_REGS_SVH
// Flag positions in the status byte
`define BAL_FLG_C 0
`define BAL_FLG_Z 1
`define BAL_FLG_N 2
`define BAL_FLG_V 3
`define BAL_FLG_S 4
`define BAL_FLG_H 5
`define BAL_FLG_RST 8'h00
`define BAL_ALL_ONES 8'hFF
`define BAL_ZERO_BYTE 8'h00
`define BAL_ONE_BYTE 8'h01
`define BAL_HALF_BIT 3
`define BAL_MSB_BIT 7
`endif

// ==== bal_pkg.sv ====
`default_nettype none
package bal_pkg;
  typedef enum logic [4:0] {
    BAL_OP_ADD = 5'h00,
    BAL_OP_ADC = 5'h01,
    BAL_OP_WORD_ADD_IMM = 5'h02,
    BAL_OP_SUB = 5'h03,
    BAL_OP_SUBTRACT_CONST = 5'h04,
    BAL_OP_SUBTRACT_BORROW = 5'h05,
    BAL_OP_SUBTRACT_BORROW_CONST = 5'h06,
    BAL_OP_WORD_SUB_IMM = 5'h07,
    BAL_OP_AND = 5'h08,
    BAL_OP_AND_CONST = 5'h09,
    BAL_OP_OR = 5'h0A,
    BAL_OP_OR_CONST = 5'h0B,
    BAL_OP_XOR_REGS = 5'h0C,
    BAL_OP_BITWISE_INVERT = 5'h0D,
    BAL_OP_TWOS_COMPLEMENT = 5'h0E,
    BAL_OP_OR_MASK_BITS = 5'h0F,
    BAL_OP_AND_CLEAR_MASK = 5'h10,
    BAL_OP_INC = 5'h11,
    BAL_OP_MINUS_ONE = 5'h12,
    BAL_OP_TEST_REGISTER = 5'h13,
    BAL_OP_ZERO_REGISTER = 5'h14,
    BAL_OP_LOAD_ALL_ONES = 5'h15
  } bal_op_t;
  typedef enum logic [1:0] {
    BAL_ST_IDLE = 2'b00,
    BAL_ST_WORD_HI = 2'b01
  } bal_state_t;
endpackage
`default_nettype wire

// ==== bal_flag_calc.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "bal_regs.svh"
// 8-bit adder with carry in and flag extraction; subtract is done as a + ~b + ~borrow
module bal_flag_calc
(
  // Operands
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  input wire logic isSub,
  // Results
  output logic [7:0] sum,
  output logic carryOut,
  output logic halfOut,
  output logic ovfOut
);
  logic [7:0] bEff;
  logic cEff;
  logic [8:0] full;
  logic [4:0] low;
  assign bEff = isSub ? ~opB : opB;
  assign cEff = isSub ? ~carryIn : carryIn;
  assign full = {1'b0, opA} + {1'b0, bEff} + {8'h00, cEff};
  assign low = {1'b0, opA[3:0]} + {1'b0, bEff[3:0]} + {4'h0, cEff};
  assign sum = full[7:0];
  // Borrow is the inverted carry for subtraction
  assign carryOut = isSub ? ~full[8] : full[8];
  assign halfOut = isSub ? ~low[4] : low[4];
  assign ovfOut = (opA[`BAL_MSB_BIT] == bEff[`BAL_MSB_BIT]) && (sum[`BAL_MSB_BIT] != opA[`BAL_MSB_BIT]);
endmodule
`default_nettype wire

// ==== bal_byte_alu.sv ====
// Operation
// - Add, add with carry: one clock, ZCNVH
// - Word add immediate: two clocks, ZCNVS
// - Subtract register or constant: one clock
// - Subtract with borrow: one clock, ZCNVH
// - Word subtract immediate: two clocks, ZCNVS
// - AND register or constant: ZNV only
// - OR register or constant: ZNV only
// - XOR registers: one clock, ZNV
// - Invert: FF minus value, ZCNV
// - OR with mask bits: ZNV
// - AND with inverted mask: ZNV
// - Test: value kept, ZNV updated
// - Clear register via self XOR: ZNV
`timescale 1ns/100ps
`default_nettype none
`include "bal_regs.svh"
module bal_byte_alu
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Request from decoder
  input wire logic opValid,
  input wire bal_pkg::bal_op_t opCode,
  input wire logic [7:0] dstVal,
  input wire logic [7:0] srcVal,
  input wire logic [7:0] dstHiVal,
  input wire logic [5:0] immVal,
  // Handshake
  output logic opReady,
  // Write back to register file
  output logic wrLo,
  output logic wrHi,
  output logic [7:0] wrData,
  // Status flags
  output logic [7:0] flags
);
  import bal_pkg::*;

  // ************************************************************
  // Byte datapath
  // ************************************************************
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic [7:0] nxt_res;
  logic nxt_wr;
  logic [7:0] aOp;
  logic [7:0] bOp;
  logic cIn;
  logic sub;
  logic [7:0] sum;
  logic cOut;
  logic hOut;
  logic vOut;
  bal_state_t state_ff;
  logic [7:0] hiSrc_ff;
  logic cLo_ff;
  logic zLo_ff;
  logic sub_ff;
  logic wrLo_ff;
  logic wrHi_ff;
  logic [7:0] wrData_ff;
  logic cFlag;

  assign cFlag = flags_ff[`BAL_FLG_C];

  function automatic logic isWord(input bal_op_t op);
    isWord = (op == BAL_OP_WORD_ADD_IMM) || (op == BAL_OP_WORD_SUB_IMM);
  endfunction

  // Shared adder operand selection
  always_comb
  begin
    aOp = dstVal;
    bOp = srcVal;
    cIn = 1'b0;
    sub = 1'b0;
    if (state_ff == BAL_ST_WORD_HI)
    begin
      aOp = hiSrc_ff;
      bOp = `BAL_ZERO_BYTE;
      cIn = cLo_ff;
      sub = sub_ff;
    end
    else
    begin
      case (opCode)
        BAL_OP_ADC: cIn = cFlag;
        BAL_OP_WORD_ADD_IMM: bOp = {2'b00, immVal};
        BAL_OP_SUB: sub = 1'b1;
        BAL_OP_SUBTRACT_CONST:
        begin
          sub = 1'b1;
        end
        BAL_OP_SUBTRACT_BORROW:
        begin
          sub = 1'b1;
          cIn = cFlag;
        end
        BAL_OP_SUBTRACT_BORROW_CONST:
        begin
          sub = 1'b1;
          cIn = cFlag;
        end
        BAL_OP_WORD_SUB_IMM:
        begin
          bOp = {2'b00, immVal};
          sub = 1'b1;
        end
        BAL_OP_TWOS_COMPLEMENT:
        begin
          aOp = `BAL_ZERO_BYTE;
          bOp = dstVal;
          sub = 1'b1;
        end
        BAL_OP_INC: bOp = `BAL_ONE_BYTE;
        BAL_OP_MINUS_ONE:
        begin
          bOp = `BAL_ONE_BYTE;
          sub = 1'b1;
        end
        default: bOp = srcVal;
      endcase
    end
  end

  // Adder carry input: carry for add, borrow for subtract, so plain subtracts pass zero
  bal_flag_calc uAdd
  (
    .opA(aOp),
    .opB(bOp),
    .carryIn(cIn),
    .isSub(sub),
    .sum(sum),
    .carryOut(cOut),
    .halfOut(hOut),
    .ovfOut(vOut)
  );

  // ************************************************************
  // Result and flag selection
  // ************************************************************
  always_comb
  begin
    nxt_res = sum;
    nxt_wr = 1'b1;
    nxt_flags = flags_ff;
    if (state_ff == BAL_ST_WORD_HI)
    begin
      nxt_flags[`BAL_FLG_C] = cOut;
      nxt_flags[`BAL_FLG_Z] = zLo_ff && (sum == `BAL_ZERO_BYTE);
      nxt_flags[`BAL_FLG_N] = sum[`BAL_MSB_BIT];
      nxt_flags[`BAL_FLG_V] = vOut;
      nxt_flags[`BAL_FLG_S] = sum[`BAL_MSB_BIT] ^ vOut;
    end
    else if (!opValid)
    begin
      nxt_wr = 1'b0;
    end
    else
    begin
      case (opCode)
        BAL_OP_AND, BAL_OP_AND_CONST: nxt_res = dstVal & srcVal;
        BAL_OP_TEST_REGISTER: nxt_res = dstVal & dstVal;
        BAL_OP_OR, BAL_OP_OR_CONST, BAL_OP_OR_MASK_BITS: nxt_res = dstVal | srcVal;
        BAL_OP_XOR_REGS: nxt_res = dstVal ^ srcVal;
        BAL_OP_ZERO_REGISTER: nxt_res = dstVal ^ dstVal;
        BAL_OP_BITWISE_INVERT: nxt_res = `BAL_ALL_ONES - dstVal;
        BAL_OP_AND_CLEAR_MASK: nxt_res = dstVal & (`BAL_ALL_ONES - srcVal);
        BAL_OP_LOAD_ALL_ONES: nxt_res = `BAL_ALL_ONES;
        default: nxt_res = sum;
      endcase
      if (opCode != BAL_OP_LOAD_ALL_ONES && !isWord(opCode))
      begin
        nxt_flags[`BAL_FLG_Z] = (nxt_res == `BAL_ZERO_BYTE);
        nxt_flags[`BAL_FLG_N] = nxt_res[`BAL_MSB_BIT];
      end
      case (opCode)
        BAL_OP_ADD, BAL_OP_ADC, BAL_OP_SUB, BAL_OP_SUBTRACT_CONST, BAL_OP_TWOS_COMPLEMENT:
        begin
          nxt_flags[`BAL_FLG_C] = cOut;
          nxt_flags[`BAL_FLG_V] = vOut;
          nxt_flags[`BAL_FLG_H] = hOut;
        end
        BAL_OP_SUBTRACT_BORROW, BAL_OP_SUBTRACT_BORROW_CONST:
        begin
          nxt_flags[`BAL_FLG_C] = cOut;
          nxt_flags[`BAL_FLG_V] = vOut;
          nxt_flags[`BAL_FLG_H] = hOut;
          // Zero only stays set across a chained subtract
          nxt_flags[`BAL_FLG_Z] = (nxt_res == `BAL_ZERO_BYTE) && flags_ff[`BAL_FLG_Z];
        end
        BAL_OP_BITWISE_INVERT:
        begin
          nxt_flags[`BAL_FLG_C] = 1'b1;
          nxt_flags[`BAL_FLG_V] = 1'b0;
        end
        BAL_OP_INC, BAL_OP_MINUS_ONE: nxt_flags[`BAL_FLG_V] = vOut;
        BAL_OP_LOAD_ALL_ONES: nxt_flags = flags_ff;
        BAL_OP_WORD_ADD_IMM, BAL_OP_WORD_SUB_IMM: nxt_flags = flags_ff;
        default: nxt_flags[`BAL_FLG_V] = 1'b0;
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (srst)
      state_ff <= BAL_ST_IDLE;
    else if (state_ff == BAL_ST_WORD_HI)
      state_ff <= BAL_ST_IDLE;
    else if (opValid && isWord(opCode))
      state_ff <= BAL_ST_WORD_HI;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      hiSrc_ff <= `BAL_ZERO_BYTE;
      cLo_ff <= 1'b0;
      zLo_ff <= 1'b0;
      sub_ff <= 1'b0;
    end
    else if (state_ff == BAL_ST_IDLE && opValid && isWord(opCode))
    begin
      hiSrc_ff <= dstHiVal;
      cLo_ff <= cOut;
      zLo_ff <= (sum == `BAL_ZERO_BYTE);
      sub_ff <= (opCode == BAL_OP_WORD_SUB_IMM);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      flags_ff <= `BAL_FLG_RST;
    else
      flags_ff <= nxt_flags;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wrLo_ff <= 1'b0;
      wrHi_ff <= 1'b0;
      wrData_ff <= `BAL_ZERO_BYTE;
    end
    else
    begin
      wrLo_ff <= nxt_wr && (state_ff == BAL_ST_IDLE) && (opCode != BAL_OP_TEST_REGISTER);
      wrHi_ff <= (state_ff == BAL_ST_WORD_HI);
      wrData_ff <= nxt_res;
    end
  end

  assign opReady = (state_ff == BAL_ST_IDLE);
  assign wrLo = wrLo_ff;
  assign wrHi = wrHi_ff;
  assign wrData = wrData_ff;
  assign flags = flags_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  add_result_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opReady && opCode == BAL_OP_ADD |=> wrLo && wrData == $past(dstVal) + $past(srcVal))
    else $error("add result wrong");
  word_two_clk_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opReady && opCode == BAL_OP_WORD_ADD_IMM |=> !opReady ##1 wrHi && opReady)
    else $error("word add timing wrong");
  sub_carry_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opReady && opCode == BAL_OP_SUB |=> flags[`BAL_FLG_C] == ($past(dstVal) < $past(srcVal)))
    else $error("subtract borrow wrong");
  invert_val_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opReady && opCode == BAL_OP_BITWISE_INVERT |=> wrData == ~$past(dstVal) && flags[`BAL_FLG_C])
    else $error("invert wrong");
  logic_vclr_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opReady && opCode == BAL_OP_AND |=> !flags[`BAL_FLG_V] && $stable(flags[`BAL_FLG_C]))
    else $error("logic flags wrong");
  clear_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opReady && opCode == BAL_OP_ZERO_REGISTER |=> wrData == `BAL_ZERO_BYTE && flags[`BAL_FLG_Z])
    else $error("clear register wrong");
  inc_keep_c_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opReady && opCode == BAL_OP_INC |=> $stable(flags[`BAL_FLG_C]) && $stable(flags[`BAL_FLG_H]))
    else $error("increment touched carry");
  all_ones_a: assert property (@(posedge core_clk) disable iff (srst)
    opValid && opReady && opCode == BAL_OP_LOAD_ALL_ONES |=> wrData == `BAL_ALL_ONES && $stable(flags))
    else $error("set all wrong");
endmodule
`default_nettype wire

// ==== bal_regfile_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module bal_regfile_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Write back from the datapath
  input wire logic wrLo,
  input wire logic wrHi,
  input wire logic [7:0] wrData,
  // Stored register pair
  output logic [7:0] loReg,
  output logic [7:0] hiReg
);
  // ****************
  // Register pair store
  // ****************
  always_ff @(posedge core_clk)
    if (srst)
      loReg <= 8'h00;
    else if (wrLo)
      loReg <= wrData;
  // Kept apart so a missing high write leaves a stale byte
  always_ff @(posedge core_clk)
    if (srst)
      hiReg <= 8'h00;
    else if (wrHi)
      hiReg <= wrData;
endmodule
`default_nettype wire

// ==== byte_alu_arith_logic_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module byte_alu_arith_logic_tb;
  import bal_pkg::*;
  // ****************
  // Stimulus and scoreboard
  // ****************
  logic core_clk, srst, opValid, opReady, wrLo, wrHi;
  bal_op_t opCode;
  logic [7:0] dstVal, srcVal, dstHiVal, wrData, flags, loReg, hiReg, mf;
  logic [5:0] immVal;
  logic [31:0] lfsr;
  logic [16:0] noteQ[$];
  int errCount, checkCount;
  bal_byte_alu dut (.core_clk(core_clk), .srst(srst), .opValid(opValid), .opCode(opCode), .dstVal(dstVal),
    .srcVal(srcVal), .dstHiVal(dstHiVal), .immVal(immVal), .opReady(opReady), .wrLo(wrLo), .wrHi(wrHi),
    .wrData(wrData), .flags(flags));
  bal_regfile_model partner (.core_clk(core_clk), .srst(srst), .wrLo(wrLo), .wrHi(wrHi), .wrData(wrData),
    .loReg(loReg), .hiReg(hiReg));
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] nextRnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic finishTest();
    if (errCount == 0 && checkCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Reference: notes are {high write, data, flags}; mf tracks the flags
  task automatic calc(input bal_op_t op, input logic [7:0] d, input logic [7:0] s, input logic [7:0] h,
    input logic [5:0] i);
    logic [8:0] r;
    logic [16:0] w;
    logic [7:0] f, l;
    logic sb, ci;
    f = mf;
    sb = op inside {BAL_OP_SUB, BAL_OP_SUBTRACT_CONST, BAL_OP_SUBTRACT_BORROW, BAL_OP_SUBTRACT_BORROW_CONST,
      BAL_OP_TWOS_COMPLEMENT, BAL_OP_MINUS_ONE};
    ci = op inside {BAL_OP_ADC, BAL_OP_SUBTRACT_BORROW, BAL_OP_SUBTRACT_BORROW_CONST} ? mf[0] : 1'h0;
    if (op == BAL_OP_TWOS_COMPLEMENT)
    begin
      s = d;
      d = 8'h00;
    end
    if (op inside {BAL_OP_INC, BAL_OP_MINUS_ONE})
      s = 8'h01;
    r = sb ? {1'h0, d} - {1'h0, s} - {8'h00, ci} : {1'h0, d} + {1'h0, s} + {8'h00, ci};
    l = r[7:0];
    case (op)
      BAL_OP_AND, BAL_OP_AND_CONST: l = d & s;
      BAL_OP_OR, BAL_OP_OR_CONST, BAL_OP_OR_MASK_BITS: l = d | s;
      BAL_OP_XOR_REGS: l = d ^ s;
      BAL_OP_BITWISE_INVERT: l = ~d;
      BAL_OP_AND_CLEAR_MASK: l = d & ~s;
      BAL_OP_ZERO_REGISTER: l = 8'h00;
      BAL_OP_TEST_REGISTER: l = d;
      BAL_OP_LOAD_ALL_ONES: l = 8'hFF;
      default: ;
    endcase
    f[1] = l == 8'h00;
    f[2] = l[7];
    f[3] = sb ? (d[7] & ~s[7] & ~l[7]) | (~d[7] & s[7] & l[7])
      : (d[7] & s[7] & ~l[7]) | (~d[7] & ~s[7] & l[7]);
    if (op <= BAL_OP_SUBTRACT_BORROW_CONST || op == BAL_OP_TWOS_COMPLEMENT)
    begin
      f[0] = r[8];
      f[5] = sb ? {1'h0, d[3:0]} < {1'h0, s[3:0]} + ci : {1'h0, d[3:0]} + s[3:0] + ci > 5'h0F;
      f[1] = f[1] & (mf[1] | !(op inside {BAL_OP_SUBTRACT_BORROW, BAL_OP_SUBTRACT_BORROW_CONST}));
    end
    else if (!(op inside {BAL_OP_INC, BAL_OP_MINUS_ONE}))
      f[3] = 1'h0;
    if (op == BAL_OP_BITWISE_INVERT)
      f[0] = 1'h1;
    if (op == BAL_OP_LOAD_ALL_ONES)
      f = mf;
    if (op inside {BAL_OP_WORD_ADD_IMM, BAL_OP_WORD_SUB_IMM})
    begin
      w = op == BAL_OP_WORD_SUB_IMM ? {1'h0, h, d} - {11'h000, i} : {1'h0, h, d} + {11'h000, i};
      f = mf;
      f[0] = w[16];
      f[1] = w[15:0] == 16'h0000;
      f[2] = w[15];
      f[3] = op == BAL_OP_WORD_SUB_IMM ? h[7] & ~w[15] : ~h[7] & w[15];
      f[4] = f[2] ^ f[3];
      noteQ.push_back({1'h0, w[7:0], mf});
      noteQ.push_back({1'h1, w[15:8], f});
    end
    else if (op != BAL_OP_TEST_REGISTER)
      noteQ.push_back({1'h0, l, f});
    mf = f;
  endtask
  // Holds the request until an edge sees opReady; a request after a word op is refused once
  task automatic send(input bal_op_t op, input logic [7:0] d, input logic [7:0] s, input logic [7:0] h,
    input logic [5:0] i);
    int n;
    opValid <= 1'h1;
    opCode <= op;
    dstVal <= d;
    srcVal <= s;
    dstHiVal <= h;
    immVal <= i;
    calc(op, d, s, h, i);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (opReady !== 1'h1 && n < 20);
    if (n >= 20)
    begin
      errCount++;
      finishTest();
    end
  endtask
  task automatic b(input bal_op_t op, input logic [7:0] d, input logic [7:0] s);
    send(op, d, s, 8'h00, 6'h00);
  endtask
  task automatic idle();
    opValid <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic testOp(input logic [7:0] d);
    b(BAL_OP_TEST_REGISTER, d, 8'h00);
    idle();
    @(negedge core_clk);
    chk({9'h000, flags}, {9'h000, mf});
    @(posedge core_clk);
  endtask
  always @(negedge core_clk)
    if (!srst && (wrLo || wrHi))
    begin
      if (noteQ.size() == 0)
      begin
        errCount++;
        $display("[ERR] %0t got %h exp %h", $time, wrData, 8'h00);
      end
      else
        chk({wrHi, wrData, flags}, noteQ.pop_front());
    end
  initial
  begin
    srst = 1'h1;
    opValid = 1'h0;
    opCode = BAL_OP_ADD;
    dstVal = 8'h00;
    srcVal = 8'h00;
    dstHiVal = 8'h00;
    immVal = 6'h00;
    mf = 8'h00;
    lfsr = 32'h36DC;
    errCount = 0;
    checkCount = 0;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    chk({wrHi, wrData, flags}, 17'h00000);
    chk({15'h0000, opReady, wrLo}, 17'h00002);
    @(posedge core_clk);
    srst <= 1'h0;
    b(BAL_OP_ADD, 8'h0F, 8'h01);
    b(BAL_OP_ADD, 8'h7F, 8'h01);
    b(BAL_OP_ADD, 8'hFF, 8'h01);
    b(BAL_OP_ADC, 8'h00, 8'h00);
    b(BAL_OP_SUB, 8'h00, 8'h01);
    b(BAL_OP_SUBTRACT_BORROW, 8'h05, 8'h04);
    b(BAL_OP_SUBTRACT_CONST, 8'h80, 8'h01);
    b(BAL_OP_SUB, 8'h03, 8'h03);
    b(BAL_OP_SUBTRACT_BORROW_CONST, 8'h02, 8'h02);
    send(BAL_OP_WORD_ADD_IMM, 8'hFF, 8'h01, 8'hFF, 6'h01);
    send(BAL_OP_WORD_SUB_IMM, 8'h00, 8'h00, 8'h00, 6'h3F);
    send(BAL_OP_WORD_SUB_IMM, 8'h00, 8'h00, 8'h80, 6'h01);
    idle();
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({1'h0, hiReg, loReg}, 17'h07FFF);
    @(posedge core_clk);
    b(BAL_OP_TWOS_COMPLEMENT, 8'h80, 8'h00);
    b(BAL_OP_INC, 8'h7F, 8'h00);
    b(BAL_OP_TWOS_COMPLEMENT, 8'h00, 8'h00);
    b(BAL_OP_MINUS_ONE, 8'h80, 8'h00);
    b(BAL_OP_AND_CLEAR_MASK, 8'hF0, 8'h30);
    b(BAL_OP_OR_MASK_BITS, 8'h00, 8'h00);
    b(BAL_OP_BITWISE_INVERT, 8'hFF, 8'h00);
    b(BAL_OP_ZERO_REGISTER, 8'h5A, 8'hA5);
    b(BAL_OP_LOAD_ALL_ONES, 8'h00, 8'h00);
    testOp(8'h00);
    testOp(8'h80);
    for (int k = 0; k < 6; k++)
      for (int o = 0; o < 22; o++)
        if (o != 19)
        begin
          repeat (8) lfsr = nextRnd(lfsr);
          send(bal_op_t'(o[4:0]), lfsr[7:0], lfsr[15:8], lfsr[23:16], lfsr[29:24]);
        end
    idle();
    repeat (4) @(posedge core_clk);
    chk({16'h0000, noteQ.size() == 0}, 17'h00001);
    finishTest();
  end
endmodule
`default_nettype wire
